// [core/lac_ci_filter.sv]
/*
 Double last look filter for the 4-bit control channel input.
 Assumes frame_tick pulses once per frame with the new field in ci_raw.
*/
`timescale 1ns/1ns
`default_nettype none
module lac_ci_filter
   import lac_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic rst, // async reset, active high
   input wire logic frame_tick, // one pulse per frame
   input wire logic [3:0] ci_raw, // field captured this frame
   output logic [3:0] ci_valid, // accepted code
   output logic ci_change // pulse when accepted code changes
);
   logic [3:0] last_r;
   logic [3:0] valid_r;
   logic chg_r;
   wire accept = frame_tick && (ci_raw == last_r) && (ci_raw != valid_r);
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         last_r <= DEACT_IND_DOWN;
         valid_r <= DEACT_IND_DOWN;
         chg_r <= 1'b0;
      end else begin
         chg_r <= accept;
         if (frame_tick) last_r <= ci_raw;
         if (accept) valid_r <= ci_raw;
      end
   end
   assign ci_valid = valid_r;
   assign ci_change = chg_r;
   a_dll_two_frames: assert property (@(posedge clock) disable iff (rst)
      $changed(valid_r) |-> ($past(last_r) == valid_r && last_r == valid_r))
      else $error("code accepted without repeat");
endmodule
`default_nettype wire

// [core/lac_pkg.sv]
/*
 Shared constants for the line activation controller: control channel codes,
 line signal encodings, modes, frame bit positions and timing counts.
 Assumes an 8 kHz frame strobe derived from the 100 MHz clock.
*/
package lac_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int FRAME_HZ = 8000;
   localparam int FRAME_DIV = CLK_HZ / FRAME_HZ;
   localparam logic [13:0] FRAME_DIV_M1 = 14'(FRAME_DIV - 1);
   // frame bit positions of the 4-bit control field
   localparam int CI_MSB_POS = 27;
   localparam int CI_LSB_POS = 30;
   localparam logic [5:0] FRAME_BITS_M1 = 6'h1F;
   // times in ms, converted to frame counts (8 frames per ms)
   localparam int T_REPEAT_LT_MS = 12;
   localparam int T_REPEAT_NT_MS = 6;
   localparam int T_START_LT_MS = 7;
   localparam int T_START_NT_MS = 13;
   localparam int FRAMES_PER_MS = FRAME_HZ / 1000;
   localparam logic [7:0] REPEAT_LT_FR = 8'(T_REPEAT_LT_MS * FRAMES_PER_MS);
   localparam logic [7:0] REPEAT_NT_FR = 8'(T_REPEAT_NT_MS * FRAMES_PER_MS);
   localparam logic [7:0] START_LT_FR = 8'(T_START_LT_MS * FRAMES_PER_MS);
   localparam logic [7:0] START_NT_FR = 8'(T_START_NT_MS * FRAMES_PER_MS);
   localparam logic [2:0] PWRDN_FRAMES = 3'h4;
   // downstream (input) codes
   localparam logic [3:0] DEACT_REQUEST = 4'h0;
   localparam logic [3:0] ACT_REQ_NO_LOOP = 4'h8;
   localparam logic [3:0] ACT_REQ_LOCAL_LOOP = 4'h9;
   localparam logic [3:0] ACT_REQ_LOOP_TWO = 4'hA;
   localparam logic [3:0] ACT_REQ_LOOP_FOUR = 4'hB;
   localparam logic [3:0] ACT_IND_NO_LOOP = 4'hC;
   localparam logic [3:0] ACT_IND_WITH_LOOP = 4'hE;
   localparam logic [3:0] DEACT_IND_DOWN = 4'hF;
   localparam logic [3:0] TIMING_REQUEST = 4'h0;
   // output codes
   localparam logic [3:0] DEACT_ACK = 4'h1;
   localparam logic [3:0] FRAME_SLIP_IND = 4'h2;
   localparam logic [3:0] RESYNC_IND = 4'h4;
   localparam logic [3:0] POWER_UP_IND = 4'h7;
   localparam logic [3:0] SYNC_COMPLETE_SUM_READY = 4'h7;
   localparam logic [3:0] ACT_REQ_UP = 4'h8;
   localparam logic [3:0] ACT_IND_UP = 4'hC;
   localparam logic [3:0] DEACT_IND_UP = 4'hF;
   localparam logic [3:0] CI_RESET_VAL = 4'hF;
   // line signals sent
   localparam logic [2:0] TX_OFF = 3'h0;
   localparam logic [2:0] TX_AWAKE = 3'h1;
   localparam logic [2:0] TX_U2 = 3'h2;
   localparam logic [2:0] TX_U2A = 3'h3;
   localparam logic [2:0] TX_U1A = 3'h4;
   localparam logic [2:0] TX_TRANSP = 3'h5;
   typedef enum logic [1:0] {
      LAC_MODE_LT = 2'h0,
      LAC_MODE_LTRP = 2'h1,
      LAC_MODE_NT = 2'h2,
      LAC_MODE_PABX = 2'h3
   } lac_mode_t;
endpackage

// [core/lac_top.sv]
/*
 Line activation controller: awake/acknowledge handshake, control channel
 code generation and double last look reception.
 Assumes line signal detectors provide synchronous pulses/levels from the
 line receiver on the same clock; frame sync and serial data are pins.
*/
// Function
// - awaking side repeats awake after 12 ms LT or 6 ms NT without ack; only LT and LT-RP start an awake, so the 6 ms repeat is never reached
// - after ack without repeat, send mode info after 7 ms LT, 13 ms NT
// - repeated ack at awaking side acts as incoming awake
// - awoken device acks awake, then sends mode info after 7 or 13 ms
// - repeated awake during wait restarts awoken procedure with new ack
// - output code repeats each frame, changes only on line events, input codes or timeouts
// - input code accepted only after two identical successive frames
// - LT activation request 1000 to 1011 sends awake then U2
// - LT-RP request after completed awake switches U2A to transparent U4
// - activation indications 1100 and 1110 from layer 2 are ignored in LT and LT-RP
// - after 1111 units detect awake; bus powers down after 4 frames
// - NT-PABX answers timing request with power up 0111; the NT mode does not answer it
// - NT-PABX absorbs wander, signals frame slip 0010 on buffer slip
// - resync 0100 downstream while unsynchronised at start or after sync loss
// - powered down unit seeing awake or request outputs timing request 0000
// - downstream unit signals activation request 1000 after line awake
// - on U1 or U3 output 0111 upstream and enable violation counter
// - in exchange on U3 go transparent and report activation up
// - while deactivating output deactivation acknowledge 0001
// - deactivated: output 1111, transmitter off, keep detecting awake
// - LT sync loss after activation signals resync, keeps sending U4
// - codes travel in frame bits 27 to 30, one per frame
`timescale 1ns/1ns
`default_nettype none
module lac_top
   import lac_pkg::*;
(
   input wire logic clock, // 100 MHz system clock
   input wire logic rst, // async reset, active high
   input wire logic [1:0] mode_sel, // operating mode pins
   input wire logic frame_sync_pin, // frame sync from bus
   input wire logic data_in_pin, // serial control data in
   output logic data_out, // serial control data out
   input wire logic awake_det, // pulse: awake/ack seen on line
   input wire logic sync_det, // level: receiver synchronous
   input wire logic full_sync_det, // pulse: U1/U3 detected
   input wire logic deact_det, // pulse: U0 detected on line
   input wire logic slip_det, // pulse: wander buffer slipped
   output logic [2:0] tx_info, // line signal to send
   output logic cv_count_en, // violation counter enable
   output logic bus_pwrdn_ok // frame bus may power down
);
   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_AWAKE_TX = 3'h1,
      S_ACK_WAIT = 3'h2,
      S_START_WAIT = 3'h3,
      S_SYNCING = 3'h4,
      S_ACTIVE = 3'h5,
      S_DEACT = 3'h6
   } lac_state_t;

   lac_mode_t mode;
   assign mode = lac_mode_t'(mode_sel);
   logic fs_q1, fs_q2, fs_q3, din_q1, din_q2;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fs_q1 <= 1'b0;
         fs_q2 <= 1'b0;
         fs_q3 <= 1'b0;
         din_q1 <= 1'b0;
         din_q2 <= 1'b0;
      end else begin
         fs_q1 <= frame_sync_pin;
         fs_q2 <= fs_q1;
         fs_q3 <= fs_q2;
         din_q1 <= data_in_pin;
         din_q2 <= din_q1;
      end
   end
   // bit clock as enable from divider, realigned by frame sync
   wire frame_start = fs_q2 && !fs_q3;
   localparam logic [8:0] BIT_DIV_M1 = 9'(FRAME_DIV / 32 - 1);
   localparam logic [8:0] BIT_MID = 9'(FRAME_DIV / 64 - 1);
   logic [8:0] bdiv_r;
   logic [5:0] bit_r;
   wire bit_tick = (bdiv_r == BIT_DIV_M1);
   // input taken mid-cell, clear of the cell edges that the pin synchroniser blurs
   wire bit_mid = (bdiv_r == BIT_MID);
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bdiv_r <= 9'h000;
         bit_r <= 6'h00;
      end else if (frame_start) begin
         bdiv_r <= 9'h000;
         bit_r <= 6'h00;
      end else begin
         bdiv_r <= bit_tick ? 9'h000 : bdiv_r + 9'h001;
         if (bit_tick) bit_r <= bit_r + 6'h01;
      end
   end
   wire in_ci = (bit_r >= 6'(CI_MSB_POS)) && (bit_r <= 6'(CI_LSB_POS));
   // output is loaded at the end of a cell for the cell that follows
   wire [5:0] bit_next = bit_r + 6'h01;
   wire out_ci = (bit_next >= 6'(CI_MSB_POS)) && (bit_next <= 6'(CI_LSB_POS));
   wire [1:0] out_idx = 2'h3 - 2'(bit_next - 6'(CI_MSB_POS));
   wire frame_tick = bit_tick && (bit_r == FRAME_BITS_M1);
   logic [3:0] ci_sh_r;
   logic [3:0] ci_out_r, ci_out_nxt, ci_tx_r;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ci_sh_r <= 4'h0;
         ci_tx_r <= CI_RESET_VAL;
         data_out <= 1'b1;
      end else begin
         if (bit_mid && in_ci) ci_sh_r <= {ci_sh_r[2:0], din_q2};
         if (frame_tick) ci_tx_r <= ci_out_r;
         if (bit_tick) begin
            data_out <= out_ci ? ci_tx_r[out_idx] : 1'b1;
         end
      end
   end
   logic [3:0] ci_in;
   logic ci_chg;
   lac_ci_filter u_filt (
      .clock(clock),
      .rst(rst),
      .frame_tick(frame_tick),
      .ci_raw(ci_sh_r),
      .ci_valid(ci_in),
      .ci_change(ci_chg)
   );

   wire is_lt = (mode == LAC_MODE_LT) || (mode == LAC_MODE_LTRP);
   wire act_req = ci_chg && (ci_in inside {ACT_REQ_NO_LOOP, ACT_REQ_LOCAL_LOOP,
      ACT_REQ_LOOP_TWO, ACT_REQ_LOOP_FOUR}) && is_lt;
   wire pabx_timing = ci_chg && (ci_in == TIMING_REQUEST) && !is_lt;
   wire deact_req = ci_chg && (ci_in == DEACT_REQUEST) && is_lt;
   wire [7:0] rep_lim = is_lt ? REPEAT_LT_FR : REPEAT_NT_FR;
   wire [7:0] start_lim = is_lt ? START_LT_FR : START_NT_FR;
   wire [2:0] mode_info = (mode == LAC_MODE_LT) ? TX_U2 :
      (mode == LAC_MODE_LTRP) ? TX_U2A : TX_U1A;

   lac_state_t st_r, st_nxt;
   logic [7:0] tmr_r, tmr_nxt;
   logic awoken_r, awoken_nxt, lost_r, lost_nxt, pu_r, pu_nxt;
   logic [2:0] tx_r, tx_nxt;
   logic [2:0] pd_cnt_r;
   wire tmr_done = (tmr_r == 8'h00) && frame_tick;
   always_comb begin
      st_nxt = st_r;
      tmr_nxt = (frame_tick && tmr_r != 8'h00) ? tmr_r - 8'h01 : tmr_r;
      awoken_nxt = awoken_r;
      lost_nxt = lost_r;
      pu_nxt = pu_r;
      tx_nxt = tx_r;
      ci_out_nxt = ci_out_r;
      if (pabx_timing && mode == LAC_MODE_PABX) pu_nxt = 1'b1;
      case (st_r)
         S_IDLE: begin
            tx_nxt = TX_OFF;
            if (awake_det) begin
               st_nxt = S_START_WAIT;
               awoken_nxt = 1'b1;
               tx_nxt = TX_AWAKE;
               tmr_nxt = start_lim;
               ci_out_nxt = is_lt ? ACT_REQ_UP : TIMING_REQUEST;
            end else if (act_req) begin
               st_nxt = S_AWAKE_TX;
               awoken_nxt = 1'b0;
               tx_nxt = TX_AWAKE;
               tmr_nxt = rep_lim;
            end
         end
         S_AWAKE_TX: begin
            if (awake_det) begin
               st_nxt = S_ACK_WAIT;
               tx_nxt = TX_OFF;
               tmr_nxt = start_lim;
            end else if (tmr_done) begin
               tmr_nxt = rep_lim;
               tx_nxt = TX_AWAKE;
            end
         end
         S_ACK_WAIT, S_START_WAIT: begin
            if (awake_det) begin
               st_nxt = S_START_WAIT;
               awoken_nxt = 1'b1;
               tx_nxt = TX_AWAKE;
               tmr_nxt = start_lim;
            end else if (tmr_done) begin
               st_nxt = S_SYNCING;
               tx_nxt = mode_info;
               ci_out_nxt = is_lt ? ci_out_r : RESYNC_IND;
            end
            // in S_START_WAIT the acknowledge stands until the mode signal replaces it; S_ACK_WAIT keeps TX_OFF
         end
         S_SYNCING: begin
            if (act_req && mode == LAC_MODE_LTRP) begin
               tx_nxt = TX_TRANSP;
            end
            if (full_sync_det) begin
               ci_out_nxt = is_lt ? ACT_IND_UP : SYNC_COMPLETE_SUM_READY;
               if (is_lt) begin
                  st_nxt = S_ACTIVE;
                  tx_nxt = TX_TRANSP;
               end
            end
            if (ci_chg && !is_lt && (ci_in inside {ACT_IND_NO_LOOP, ACT_IND_WITH_LOOP})) begin
               st_nxt = S_ACTIVE;
               tx_nxt = TX_TRANSP;
            end
         end
         S_ACTIVE: begin
            if (!sync_det && !lost_r) begin
               lost_nxt = 1'b1;
               ci_out_nxt = RESYNC_IND;
            end else if (sync_det && lost_r) begin
               lost_nxt = 1'b0;
               ci_out_nxt = is_lt ? ACT_IND_UP : SYNC_COMPLETE_SUM_READY;
            end
            if (slip_det && mode == LAC_MODE_PABX) ci_out_nxt = FRAME_SLIP_IND;
         end
         S_DEACT: begin
            tx_nxt = TX_OFF;
            ci_out_nxt = DEACT_ACK;
            if (tmr_done) begin
               st_nxt = S_IDLE;
               ci_out_nxt = DEACT_IND_UP;
            end
         end
         default: st_nxt = S_IDLE;
      endcase
      if (pu_r && !is_lt && st_r == S_IDLE) ci_out_nxt = POWER_UP_IND;
      if ((deact_req || deact_det) && st_r != S_IDLE && st_r != S_DEACT) begin
         st_nxt = S_DEACT;
         tmr_nxt = 8'h01;
         lost_nxt = 1'b0;
         pu_nxt = 1'b0;
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_r <= S_IDLE;
         tmr_r <= 8'h00;
         awoken_r <= 1'b0;
         lost_r <= 1'b0;
         pu_r <= 1'b0;
         tx_r <= TX_OFF;
         ci_out_r <= CI_RESET_VAL;
      end else begin
         st_r <= st_nxt;
         tmr_r <= tmr_nxt;
         awoken_r <= awoken_nxt;
         lost_r <= lost_nxt;
         pu_r <= pu_nxt;
         tx_r <= tx_nxt;
         ci_out_r <= ci_out_nxt;
      end
   end
   // bus power-down allowed after four frames of deactivation indication
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pd_cnt_r <= 3'h0;
      end else if (ci_in != DEACT_IND_DOWN || st_r != S_IDLE) begin
         pd_cnt_r <= 3'h0;
      end else if (frame_tick && pd_cnt_r != PWRDN_FRAMES) begin
         pd_cnt_r <= pd_cnt_r + 3'h1;
      end
   end
   assign bus_pwrdn_ok = (pd_cnt_r == PWRDN_FRAMES);
   assign tx_info = tx_r;
   assign cv_count_en = (ci_out_r == SYNC_COMPLETE_SUM_READY) && (st_r >= S_SYNCING);

   sequence s_wait_awake;
      st_r inside {S_ACK_WAIT, S_START_WAIT} && awake_det && !deact_det && !deact_req;
   endsequence
   sequence s_fresh_ack;
      st_r == S_START_WAIT && tmr_r == start_lim && tx_r == TX_AWAKE;
   endsequence
   a_code_hold: assert property (@(posedge clock) disable iff (rst)
      !frame_tick |=> $stable(ci_tx_r)) else $error("output code changed mid frame");
   a_idle_tx_off: assert property (@(posedge clock) disable iff (rst)
      (st_r == S_IDLE && !awake_det && !act_req) |=> tx_r == TX_OFF) else $error("tx on idle");
   a_awake_ack: assert property (@(posedge clock) disable iff (rst)
      (st_r == S_IDLE && awake_det) |=> (tx_r == TX_AWAKE && tmr_r == start_lim))
      else $error("awake not acknowledged");
   a_req_awake: assert property (@(posedge clock) disable iff (rst)
      (st_r == S_IDLE && !awake_det && act_req && !deact_req) |=> st_r == S_AWAKE_TX)
      else $error("request did not start awake");
   a_repeat_reload: assert property (@(posedge clock) disable iff (rst)
      (st_r == S_AWAKE_TX && tmr_done && !awake_det && !deact_det) |=> tmr_r == rep_lim)
      else $error("awake repeat timer not reloaded");
   a_restart_clear: assert property (@(posedge clock) disable iff (rst)
      s_wait_awake |=> s_fresh_ack) else $error("no restart");
   a_start_info: assert property (@(posedge clock) disable iff (rst)
      (st_r == S_START_WAIT && tmr_done && !awake_det && !deact_det && !deact_req)
      |=> tx_r == mode_info) else $error("mode info not sent");
   a_deact_ack: assert property (@(posedge clock) disable iff (rst)
      (st_r == S_DEACT && !tmr_done) |=> ci_out_r == DEACT_ACK) else $error("no deact ack");
   a_deact_enter: assert property (@(posedge clock) disable iff (rst)
      ((deact_req || deact_det) && !(st_r inside {S_IDLE, S_DEACT})) |=> st_r == S_DEACT)
      else $error("deactivation not entered");
   a_full_sync: assert property (@(posedge clock) disable iff (rst)
      (st_r == S_SYNCING && full_sync_det && is_lt && !deact_req && !deact_det)
      |=> (tx_r == TX_TRANSP && ci_out_r == ACT_IND_UP)) else $error("no transparency");
   a_pu_answer: assert property (@(posedge clock) disable iff (rst)
      (st_r == S_IDLE && pu_r && !is_lt) |=> ci_out_r == POWER_UP_IND)
      else $error("timing request not answered");
   a_slip_ind: assert property (@(posedge clock) disable iff (rst)
      (st_r == S_ACTIVE && slip_det && mode == LAC_MODE_PABX) |=> ci_out_r == FRAME_SLIP_IND)
      else $error("frame slip not indicated");
   a_pwrdn_wait: assert property (@(posedge clock) disable iff (rst)
      $rose(bus_pwrdn_ok) |-> $past(pd_cnt_r) == 3'h3) else $error("early bus power down");
endmodule
`default_nettype wire

// [tb/lac_bus_model.sv]
/*
 Frame bus partner: frame sync, serial control input and capture of the
 serial control output, one 4-bit code per frame.
 Assumes the design's bit cell of 390 clocks and a frame of FRAME_DIV clocks.
*/
`timescale 1ns/1ns
`default_nettype none
module lac_bus_model
   import lac_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic rst, // async reset, active high
   input wire logic [3:0] tx_code, // code sent towards the design
   input wire logic data_out, // serial output of the design
   output logic frame_sync_pin, // frame start strobe
   output logic data_in_pin, // serial control data to the design
   output logic [3:0] rx_code, // code captured in the last frame
   output logic frame_done // pulse at the end of each frame
);
   localparam int BIT_CLKS = 390;
   int cnt_r;
   int bit_n;
   logic [3:0] code_r;
   logic [3:0] shift_r;
   logic in_field;
   assign bit_n = cnt_r / BIT_CLKS;
   assign in_field = (bit_n >= 27) && (bit_n <= 30);
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt_r <= 0;
         code_r <= 4'hF;
         shift_r <= 4'hF;
         rx_code <= 4'hF;
         frame_done <= 1'b0;
         frame_sync_pin <= 1'b0;
         data_in_pin <= 1'b1;
      end else begin
         cnt_r <= (cnt_r == FRAME_DIV - 1) ? 0 : cnt_r + 1;
         // same code goes out in every frame until the bench changes it;
         // taken in bit 1 so a code set just after the frame boundary still counts
         if (cnt_r == BIT_CLKS) begin
            code_r <= tx_code;
         end
         frame_sync_pin <= (cnt_r < BIT_CLKS / 2);
         data_in_pin <= in_field ? code_r[30 - bit_n] : 1'b1;
         // mid-cell sampling keeps clear of the design's shift edges
         if (in_field && (cnt_r % BIT_CLKS == BIT_CLKS / 2)) begin
            shift_r[30 - bit_n] <= data_out;
         end
         frame_done <= (cnt_r == FRAME_DIV - 1);
         if (cnt_r == FRAME_DIV - 1) begin
            rx_code <= shift_r;
         end
      end
   end
endmodule
`default_nettype wire

// [tb/line_activation_control_test.sv]
/*
 Self-checking bench for the line activation controller: reset case, then table
 of mode and request cases, then filter and deactivation cases by hand.
 Assumes the frame bus partner model and static mode pins per reset.
*/
`timescale 1ns/1ns
`default_nettype none
module line_activation_control_test
   import lac_pkg::*;
;
   typedef struct {
      lac_mode_t mode;
      logic [3:0] code_in;
      logic awake;
      int frames;
      logic [2:0] exp_tx;
      logic chk_code;
      logic [3:0] exp_code;
   } lac_row_t;
   localparam int LIMIT = 800000;
   lac_row_t rows [9] = '{
      '{LAC_MODE_LT, 4'hF, 1'b1, 2, TX_AWAKE, 1'b1, ACT_REQ_UP},
      '{LAC_MODE_LTRP, 4'hF, 1'b1, 2, TX_AWAKE, 1'b1, ACT_REQ_UP},
      '{LAC_MODE_NT, 4'hF, 1'b1, 2, TX_AWAKE, 1'b1, TIMING_REQUEST},
      '{LAC_MODE_PABX, 4'hF, 1'b1, 2, TX_AWAKE, 1'b1, TIMING_REQUEST},
      '{LAC_MODE_LT, 4'h8, 1'b0, 4, TX_AWAKE, 1'b1, DEACT_IND_UP},
      '{LAC_MODE_LT, 4'hB, 1'b0, 4, TX_AWAKE, 1'b1, DEACT_IND_UP},
      '{LAC_MODE_LT, 4'hC, 1'b0, 4, TX_OFF, 1'b1, DEACT_IND_UP},
      '{LAC_MODE_LT, 4'hE, 1'b0, 4, TX_OFF, 1'b1, DEACT_IND_UP},
      '{LAC_MODE_PABX, 4'h0, 1'b0, 4, TX_OFF, 1'b1, POWER_UP_IND}
   };
   logic clock;
   logic rst;
   logic [1:0] mode_sel;
   logic frame_sync_pin;
   logic data_in_pin;
   logic data_out;
   logic awake_det;
   logic sync_det;
   logic full_sync_det;
   logic deact_det;
   logic slip_det;
   logic [2:0] tx_info;
   logic cv_count_en;
   logic bus_pwrdn_ok;
   logic [3:0] tx_code;
   logic [3:0] rx_code;
   logic frame_done;
   logic seen_ack;
   int miscompares;
   int samples_checked;
   int cycles;

   lac_top i_dut (
      .clock(clock), .rst(rst), .mode_sel(mode_sel),
      .frame_sync_pin(frame_sync_pin), .data_in_pin(data_in_pin),
      .data_out(data_out), .awake_det(awake_det), .sync_det(sync_det),
      .full_sync_det(full_sync_det), .deact_det(deact_det), .slip_det(slip_det),
      .tx_info(tx_info), .cv_count_en(cv_count_en), .bus_pwrdn_ok(bus_pwrdn_ok)
   );
   lac_bus_model u_bus (
      .clock(clock), .rst(rst), .tx_code(tx_code), .data_out(data_out),
      .frame_sync_pin(frame_sync_pin), .data_in_pin(data_in_pin),
      .rx_code(rx_code), .frame_done(frame_done)
   );

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic summarize;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic do_reset(input lac_mode_t m);
      @(posedge clock);
      mode_sel <= m;
      rst <= 1'b1;
      tx_code <= DEACT_IND_DOWN;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
   endtask

   task automatic pulse_awake;
      @(posedge clock);
      awake_det <= 1'b1;
      @(posedge clock);
      awake_det <= 1'b0;
   endtask

   task automatic wait_frames(input int n);
      // the edge after the frame end: codes settled, new stimulus still in time
      repeat (n) @(posedge clock iff frame_done);
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         $display("mismatch timeout expected done seen hang");
         summarize();
      end
   end

   initial begin
      rst <= 1'b1;
      mode_sel <= LAC_MODE_LT;
      awake_det <= 1'b0;
      sync_det <= 1'b0;
      full_sync_det <= 1'b0;
      deact_det <= 1'b0;
      slip_det <= 1'b0;
      tx_code <= DEACT_IND_DOWN;
      miscompares = 0;
      samples_checked = 0;
      repeat (5) @(posedge clock);
      #1;
      check("tx_info in reset", 4'h0, {1'b0, tx_info});
      check("data_out in reset", 4'h1, {3'h0, data_out});
      check("bus_pwrdn_ok in reset", 4'h0, {3'h0, bus_pwrdn_ok});
      @(posedge clock);
      rst <= 1'b0;
      // idle 1111 on the bus long enough for the power-down allowance
      wait_frames(6);
      check("bus_pwrdn_ok idle", 4'h1, {3'h0, bus_pwrdn_ok});
      check("idle code", DEACT_IND_UP, rx_code);
      check("idle tx_info", 4'h0, {1'b0, tx_info});
      check("idle cv_count_en", 4'h0, {3'h0, cv_count_en});
      $display("test reset_idle done");

      foreach (rows[i]) begin
         do_reset(rows[i].mode);
         tx_code <= rows[i].code_in;
         if (rows[i].awake) begin
            pulse_awake();
         end
         wait_frames(rows[i].frames);
         check("row tx_info", {1'b0, rows[i].exp_tx}, {1'b0, tx_info});
         if (rows[i].chk_code) begin
            check("row code", rows[i].exp_code, rx_code);
         end
         $display("test row %0d done", i);
      end

      // a request seen in one frame only must not be taken
      do_reset(LAC_MODE_LT);
      wait_frames(1);
      tx_code <= ACT_REQ_NO_LOOP;
      wait_frames(1);
      tx_code <= DEACT_IND_DOWN;
      wait_frames(4);
      check("single frame request", 4'h0, {1'b0, tx_info});
      check("single frame code", DEACT_IND_UP, rx_code);
      $display("test single_frame done");

      // deactivation after an awake: acknowledge first, then 1111
      do_reset(LAC_MODE_LT);
      pulse_awake();
      wait_frames(2);
      tx_code <= DEACT_REQUEST;
      seen_ack = 1'b0;
      repeat (7) begin
         wait_frames(1);
         if (rx_code === DEACT_ACK) begin
            seen_ack = 1'b1;
         end
      end
      check("deact ack seen", 4'h1, {3'h0, seen_ack});
      check("deact final code", DEACT_IND_UP, rx_code);
      check("deact tx_info", 4'h0, {1'b0, tx_info});
      $display("test deactivation done");
      summarize();
   end
endmodule
`default_nettype wire
